// [pmi_pkg.sv]
// Package for the port 0 MII/RMII input side: modes, timing, pin and stream structs.
// Assumes a 100 MHz core clock; all users write pmi_pkg::name.
package pmi_pkg;

    // Port operating modes: bit 0 set = PHY role, bit 1 set = RMII
    typedef enum logic [1:0] {
        PMI_MII_MAC  = 2'b00,
        PMI_MII_PHY  = 2'b01,
        PMI_RMII_MAC = 2'b10,
        PMI_RMII_PHY = 2'b11
    } pmi_mode_e;

    // Frame tracking states
    typedef enum logic [1:0] {
        PMI_IDLE  = 2'b00,
        PMI_RECV  = 2'b01,
        PMI_ABORT = 2'b10
    } pmi_state_e;

    // Timing: core clock period, MII clock half period, RMII sample interval
    localparam int CLK_PERIOD_NS   = 10;
    localparam int MII_HALF_NS     = 20;
    localparam int RMII_PERIOD_NS  = 20;
    localparam int MII_HALF_CYC    = (MII_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RMII_CYC        = (RMII_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W           = 4;
    localparam logic [CNT_W-1:0] MII_LIMIT  = CNT_W'(MII_HALF_CYC - 1);
    localparam logic [CNT_W-1:0] RMII_LIMIT = CNT_W'(RMII_CYC - 1);

    // Values after reset and fixed codes
    localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;
    localparam logic [3:0]       LPI_CODE  = 4'h1;

    // Pins sampled into the core clock domain
    typedef struct packed {
        logic [1:0] mode;
        logic       virtual_phy_isolate;
        logic       port0_in_clock;
        logic       port0_in_valid;
        logic       port0_in_error;
        logic [3:0] port0_in_data_bus;
    } pmi_pin_s;

    localparam pmi_pin_s PIN_RESET = '0;

    // Received stream toward the switch core, one beat per sample
    typedef struct packed {
        logic       valid;
        logic [3:0] data;
        logic       two_bit;
        logic       error;
        logic       abort;
        logic       lpi;
    } pmi_rx_s;

    localparam pmi_rx_s RX_RESET = '0;

endpackage

// [pmi_port_input.sv]
// Port 0 MII/RMII input side: samples data, valid and error pins and
// produces a per-beat receive stream; drives the clock pin in MII PHY mode.
// Assumes mode and isolate are quasi-static levels; all pins are asynchronous.
//
// Overview of operation
// - In MAC modes the lowest data pin is taken as receive data bit 0.
// - In PHY modes the lowest data pin is taken as frame data bit 0 from the MAC.
// - In MII MAC mode data and error are accepted only while receive valid is high, except the low power idle code.
// - In PHY modes transmit enable qualifies four bits in MII and two bits in RMII.
// - In RMII MAC mode the valid pin is carrier sense and data valid combined.
// - In MII MAC mode the error pin flags a receive error or low power idle.
// - In MII PHY mode an error from the MAC aborts the frame being received.
// - In RMII MAC mode the error pin marks the received beats as errored.
// - In RMII PHY mode the error pin is ignored.
// - In PHY modes the isolate bit makes the data, valid and error pins ignored.
// - In MII MAC mode the clock pin is the PHY receive clock timing the inputs.
// - In MII PHY mode the device drives the clock pin, disabled while isolated.
// - In RMII modes the clock pin is unused for timing.
// - In MAC modes the next data pin carries receive data bit 1.
`timescale 1ns/1ps
`default_nettype none

module pmi_port_input (
    input  wire logic               mclk_i,
    input  wire logic               reset_i,
    input  wire pmi_pkg::pmi_pin_s  pins_i,
    output var  logic               clock_pin_o,
    output var  logic               clock_pin_oe_o,
    output var  pmi_pkg::pmi_rx_s   rx_o,
    output var  logic               frame_active_o
);

    pmi_pkg::pmi_pin_s              sync1_reg;
    pmi_pkg::pmi_pin_s              sync2_reg;
    logic                           clk_prev_reg;
    logic [pmi_pkg::CNT_W-1:0]      cnt_reg;
    logic [pmi_pkg::CNT_W-1:0]      cnt_next;
    logic                           gen_clk_reg;
    pmi_pkg::pmi_state_e            state_reg;
    pmi_pkg::pmi_state_e            state_next;
    pmi_pkg::pmi_rx_s               rx_next;

    wire pmi_pkg::pmi_mode_e        mode;
    wire logic                      is_phy;
    wire logic                      is_rmii;
    wire logic                      isolated;
    wire logic                      mac_edge;
    wire logic [pmi_pkg::CNT_W-1:0] limit;
    wire logic                      tick;
    wire logic                      sample_en;
    wire logic                      eff_valid;
    wire logic                      eff_error;
    wire logic [3:0]                eff_data;
    wire logic                      abort_now;
    wire logic                      accept;

    // Two-stage synchroniser for every pin; only stage two is read
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            sync1_reg <= pmi_pkg::PIN_RESET;
            sync2_reg <= pmi_pkg::PIN_RESET;
        end else begin
            sync1_reg <= pins_i;
            sync2_reg <= sync1_reg;
        end
    end

    // Mode and isolate decode
    assign mode     = pmi_pkg::pmi_mode_e'(sync2_reg.mode);
    assign is_phy   = sync2_reg.mode[0];
    assign is_rmii  = sync2_reg.mode[1];
    assign isolated = is_phy & sync2_reg.virtual_phy_isolate;

    // Rising edge of the external receive clock, MII MAC only
    assign mac_edge = (mode == pmi_pkg::PMI_MII_MAC) & sync2_reg.port0_in_clock
                      & ~clk_prev_reg;

    // Divider: MII half period or RMII sample interval
    assign limit    = is_rmii ? pmi_pkg::RMII_LIMIT : pmi_pkg::MII_LIMIT;
    assign tick     = (cnt_reg >= limit);
    assign cnt_next = tick ? pmi_pkg::CNT_RESET : cnt_reg + 4'h1;

    // Sample strobe per mode; the clock pin never times RMII
    assign sample_en = is_rmii ? tick :
                       is_phy  ? (tick & ~gen_clk_reg) :
                                 mac_edge;

    // Effective pin values after isolate and mode masking
    assign eff_valid = sync2_reg.port0_in_valid & ~isolated;
    assign eff_error = sync2_reg.port0_in_error & ~isolated
                       & (mode != pmi_pkg::PMI_RMII_PHY);
    assign eff_data  = isolated ? 4'h0 :
                       is_rmii  ? {2'h0, sync2_reg.port0_in_data_bus[1:0]} :
                                  sync2_reg.port0_in_data_bus;

    // Transmit error from the MAC kills the frame
    assign abort_now = (mode == pmi_pkg::PMI_MII_PHY) & eff_valid & eff_error;
    assign accept    = sample_en & eff_valid & ~abort_now
                       & (state_reg != pmi_pkg::PMI_ABORT);

    // Frame state machine, advanced on sample strobes
    always_comb begin
        state_next = state_reg;
        if (sample_en) begin
            case (state_reg)
                pmi_pkg::PMI_IDLE: begin
                    if (abort_now) begin
                        state_next = pmi_pkg::PMI_ABORT;
                    end else if (eff_valid) begin
                        state_next = pmi_pkg::PMI_RECV;
                    end
                end
                pmi_pkg::PMI_RECV: begin
                    if (abort_now) begin
                        state_next = pmi_pkg::PMI_ABORT;
                    end else if (!eff_valid) begin
                        state_next = pmi_pkg::PMI_IDLE;
                    end
                end
                pmi_pkg::PMI_ABORT: begin
                    if (!eff_valid) begin
                        state_next = pmi_pkg::PMI_IDLE;
                    end
                end
                default: begin
                    state_next = pmi_pkg::PMI_IDLE;
                end
            endcase
        end
    end

    // Stream beat built from the current sample
    always_comb begin
        rx_next         = pmi_pkg::RX_RESET;
        rx_next.valid   = accept;
        rx_next.data    = accept ? eff_data : 4'h0;
        rx_next.two_bit = accept & is_rmii;
        rx_next.error   = accept & eff_error & ~is_phy;
        rx_next.abort   = sample_en & abort_now
                          & (state_reg != pmi_pkg::PMI_ABORT);
        rx_next.lpi     = sample_en & (mode == pmi_pkg::PMI_MII_MAC) & ~eff_valid
                          & eff_error & (eff_data == pmi_pkg::LPI_CODE);
    end

    // Counter, generated clock and edge history
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_reg      <= pmi_pkg::CNT_RESET;
            gen_clk_reg  <= 1'b0;
            clk_prev_reg <= 1'b0;
        end else begin
            cnt_reg      <= cnt_next;
            gen_clk_reg  <= tick ? ~gen_clk_reg : gen_clk_reg;
            clk_prev_reg <= sync2_reg.port0_in_clock;
        end
    end

    // Registered outputs
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            state_reg      <= pmi_pkg::PMI_IDLE;
            rx_o           <= pmi_pkg::RX_RESET;
            frame_active_o <= 1'b0;
            clock_pin_o    <= 1'b0;
            clock_pin_oe_o <= 1'b0;
        end else begin
            state_reg      <= state_next;
            rx_o           <= rx_next;
            frame_active_o <= (state_next == pmi_pkg::PMI_RECV);
            clock_pin_o    <= gen_clk_reg;
            clock_pin_oe_o <= (mode == pmi_pkg::PMI_MII_PHY) & ~isolated;
        end
    end

    // Checks
    sequence s_rmii_gap;
        !tick ##1 tick;
    endsequence

    property p_valid_cause;
        @(posedge mclk_i) disable iff (reset_i)
        rx_o.valid |-> $past(eff_valid) && $past(sample_en);
    endproperty
    a_valid_cause: assert property (p_valid_cause) else $error("beat without valid");

    property p_bit0;
        @(posedge mclk_i) disable iff (reset_i)
        rx_o.valid |-> rx_o.data[0] == $past(sync2_reg.port0_in_data_bus[0]);
    endproperty
    a_bit0: assert property (p_bit0) else $error("data bit 0 mismatch");

    property p_rmii_width;
        @(posedge mclk_i) disable iff (reset_i)
        rx_o.valid && $past(is_rmii) |-> rx_o.two_bit && rx_o.data[3:2] == 2'h0
            && rx_o.data[1] == $past(sync2_reg.port0_in_data_bus[1]);
    endproperty
    a_rmii_width: assert property (p_rmii_width) else $error("rmii width wrong");

    property p_rmii_phy_no_error;
        @(posedge mclk_i) disable iff (reset_i)
        $past(mode == pmi_pkg::PMI_RMII_PHY) |-> !rx_o.error && !rx_o.abort;
    endproperty
    a_rmii_phy_no_error: assert property (p_rmii_phy_no_error) else $error("error used");

    property p_isolate;
        @(posedge mclk_i) disable iff (reset_i)
        $past(isolated) |-> !rx_o.valid && !rx_o.error && !rx_o.abort;
    endproperty
    a_isolate: assert property (p_isolate) else $error("input seen while isolated");

    property p_clock_oe;
        @(posedge mclk_i) disable iff (reset_i)
        clock_pin_oe_o |-> $past(mode == pmi_pkg::PMI_MII_PHY) && !$past(isolated);
    endproperty
    a_clock_oe: assert property (p_clock_oe) else $error("clock driven wrongly");

    property p_abort_blocks;
        @(posedge mclk_i) disable iff (reset_i)
        rx_o.abort |-> !rx_o.valid ##1 (state_reg == pmi_pkg::PMI_ABORT);
    endproperty
    a_abort_blocks: assert property (p_abort_blocks) else $error("abort not held");

    property p_mac_edge;
        @(posedge mclk_i) disable iff (reset_i)
        rx_o.valid && $past(mode == pmi_pkg::PMI_MII_MAC) |-> $past(mac_edge);
    endproperty
    a_mac_edge: assert property (p_mac_edge) else $error("sample off clock edge");

    property p_rmii_tick;
        @(posedge mclk_i) disable iff (reset_i)
        is_rmii && tick && $stable(sync2_reg.mode) |=> s_rmii_gap;
    endproperty
    a_rmii_tick: assert property (p_rmii_tick) else $error("rmii strobe spacing");

    property p_error_cause;
        @(posedge mclk_i) disable iff (reset_i)
        rx_o.error |-> rx_o.valid && $past(sync2_reg.port0_in_error) && !$past(is_phy);
    endproperty
    a_error_cause: assert property (p_error_cause) else $error("spurious error");

endmodule

`default_nettype wire

// [pmi_link_model.sv]
// Link partner model: the external PHY or MAC driving the port 0 input pins.
// Assumes a 100 MHz mclk_i; released lines fall to the pull-down level 0.
`timescale 1ns/1ps
`default_nettype none

module pmi_link_model (
    input  wire logic       mclk_i,
    input  wire logic       clock_pin_i,
    output var  logic       lclk_o,
    output var  logic       valid_o,
    output var  logic       error_o,
    output var  logic [3:0] data_o
);
    // Pull-downs hold every line low until the first beat
    initial {lclk_o, valid_o, error_o, data_o} = '0;

    // One beat: own 80 ns clock in MII MAC, one device clock in MII PHY, 40 ns hold else
    task automatic beat(input logic [1:0] m, input logic v, input logic e,
                        input logic [3:0] d);
        if (m == 2'b01) begin
            do @(posedge mclk_i); while (clock_pin_i);
            do @(posedge mclk_i); while (!clock_pin_i); // Change just after device edge
        end else begin
            @(posedge mclk_i);
        end
        valid_o <= v;
        error_o <= e;
        data_o  <= d;
        if (m == 2'b00) begin
            repeat (3) @(posedge mclk_i);
            lclk_o <= 1'b1;
            repeat (4) @(posedge mclk_i);
            lclk_o <= 1'b0; // Clock rests low between frames
        end else if (m != 2'b01) begin
            repeat (3) @(posedge mclk_i);
        end
    endtask
endmodule

`default_nettype wire

// [port0_mii_rmii_input_side_tb.sv]
// Testbench for the port 0 input side: one task per mode, beats checked in order.
// Assumes pmi_port_input and pmi_link_model are compiled before it.
`timescale 1ns/1ps
`default_nettype none

module port0_mii_rmii_input_side_tb;
    logic              mclk_i;
    logic              reset_i;
    logic [1:0]        mode;
    logic              iso;
    logic              lclk;
    logic              valid;
    logic              error;
    logic [3:0]        data;
    logic              clock_pin_o;
    logic              clock_pin_oe_o;
    logic              frame_active_o;
    logic              prev_clk;
    pmi_pkg::pmi_pin_s pins_i;
    pmi_pkg::pmi_rx_s  rx_o;
    logic [7:0]        got_q[$];
    logic [7:0]        exp_q[$];
    int                error_cnt;
    int                checked;
    int                aborts;
    int                lpis;
    int                toggles;
    int                frames;
    logic              prev_act;
    int                cyc;

    // Pin bundle in struct order
    assign pins_i = {mode, iso, lclk, valid, error, data};

    pmi_port_input u_pmi_port_input (
        .mclk_i         (mclk_i),
        .reset_i        (reset_i),
        .pins_i         (pins_i),
        .clock_pin_o    (clock_pin_o),
        .clock_pin_oe_o (clock_pin_oe_o),
        .rx_o           (rx_o),
        .frame_active_o (frame_active_o)
    );

    pmi_link_model u_pmi_link_model (
        .mclk_i      (mclk_i),
        .clock_pin_i (clock_pin_o),
        .lclk_o      (lclk),
        .valid_o     (valid),
        .error_o     (error),
        .data_o      (data)
    );

    // Core clock
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    // Monitor: collects beats, pulses and clock toggles; cuts a hang short
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        prev_clk <= clock_pin_o;
        if (rx_o.valid === 1'b1) got_q.push_back({2'b00, rx_o.error, rx_o.two_bit, rx_o.data});
        if (rx_o.abort === 1'b1) aborts <= aborts + 1;
        if (rx_o.lpi === 1'b1) lpis <= lpis + 1;
        if (clock_pin_o !== prev_clk) toggles <= toggles + 1;
        prev_act <= frame_active_o;
        if (frame_active_o === 1'b1 && prev_act !== 1'b1) frames <= frames + 1;
        if (cyc == 5000) begin
            error_cnt = error_cnt + 1;
            final_report();
        end
    end

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Beats seen against beats expected, in order
    task automatic check_q();
        cmp(8'(got_q.size()), 8'(exp_q.size()));
        foreach (exp_q[i]) if (i < got_q.size()) cmp(got_q[i], exp_q[i]);
    endtask

    // Reset into a mode and clear the monitor except its clock toggle and cycle counts
    task automatic start(input logic [1:0] m);
        reset_i <= 1'b1;
        mode <= m;
        iso <= 1'b0;
        repeat (6) @(posedge mclk_i);
        reset_i <= 1'b0;
        repeat (6) @(posedge mclk_i);
        got_q = {};
        aborts = 0;
        lpis = 0;
        frames = 0;
    endtask

    task automatic finish_frame();
        u_pmi_link_model.beat(2'b10, 1'b0, 1'b0, 4'h0);
        repeat (12) @(posedge mclk_i);
    endtask

    task automatic t_mii_mac();
        start(2'b00);
        u_pmi_link_model.beat(2'b00, 1'b1, 1'b0, 4'hA);
        u_pmi_link_model.beat(2'b00, 1'b1, 1'b0, 4'h5);
        u_pmi_link_model.beat(2'b00, 1'b1, 1'b1, 4'h3);
        u_pmi_link_model.beat(2'b00, 1'b0, 1'b1, 4'h1);
        u_pmi_link_model.beat(2'b00, 1'b0, 1'b0, 4'hF);
        finish_frame();
        exp_q = {8'h0A, 8'h05, 8'h23};
        check_q();
        cmp(8'(lpis), 8'h01);
        cmp(8'(frames), 8'h01);
        cmp({7'h00, clock_pin_oe_o}, 8'h00);
    endtask

    task automatic t_rmii_mac();
        start(2'b10);
        u_pmi_link_model.beat(2'b10, 1'b1, 1'b0, 4'hE);
        u_pmi_link_model.beat(2'b10, 1'b1, 1'b1, 4'h1);
        finish_frame();
        exp_q = {8'h12, 8'h12, 8'h31, 8'h31};
        check_q();
        cmp(8'(frames), 8'h01);
    endtask

    task automatic t_mii_phy();
        int base;
        start(2'b01);
        cmp({7'h00, clock_pin_oe_o}, 8'h01);
        base = toggles;
        repeat (40) @(posedge mclk_i);
        cmp(8'(toggles - base), 8'h14);
        u_pmi_link_model.beat(2'b01, 1'b1, 1'b0, 4'h1);
        u_pmi_link_model.beat(2'b01, 1'b1, 1'b1, 4'h2);
        u_pmi_link_model.beat(2'b01, 1'b1, 1'b0, 4'h3);
        u_pmi_link_model.beat(2'b01, 1'b0, 1'b0, 4'h0);
        u_pmi_link_model.beat(2'b01, 1'b1, 1'b0, 4'h4);
        u_pmi_link_model.beat(2'b01, 1'b0, 1'b0, 4'h0);
        finish_frame();
        exp_q = {8'h01, 8'h04};
        check_q();
        cmp(8'(aborts), 8'h01);
        cmp(8'(frames), 8'h02);
        iso <= 1'b1;
        repeat (8) @(posedge mclk_i);
        got_q = {};
        cmp({7'h00, clock_pin_oe_o}, 8'h00);
        u_pmi_link_model.beat(2'b10, 1'b1, 1'b0, 4'h5);
        finish_frame();
        exp_q = {};
        check_q();
        cmp(8'(frames), 8'h02);
    endtask

    task automatic t_rmii_phy();
        start(2'b11);
        u_pmi_link_model.beat(2'b11, 1'b1, 1'b1, 4'h6);
        u_pmi_link_model.beat(2'b11, 1'b1, 1'b0, 4'h1);
        finish_frame();
        exp_q = {8'h12, 8'h12, 8'h11, 8'h11};
        check_q();
        cmp(8'(frames), 8'h01);
    endtask

    task automatic final_report();
        if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Main sequence
    initial begin
        reset_i = 1'b1;
        mode = 2'b00;
        iso = 1'b0;
        error_cnt = 0;
        checked = 0;
        cyc = 0;
        toggles = 0;
        aborts = 0;
        lpis = 0;
        frames = 0;
        t_mii_mac();
        t_rmii_mac();
        t_mii_phy();
        t_rmii_phy();
        final_report();
    end
endmodule

`default_nettype wire
